// [mxa_core.sv]
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "mxa_defs.svh"
module mxa_core
  import mxa_pkg::*;
#(
  parameter int AW  = `MXA_AW,
  parameter int PCW = `MXA_PCW
) (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           reset,
  // Instruction request
  input  wire logic           start,
  input  wire mxa_op_e        op,
  input  wire logic [AW-1:0]  far_addr,
  input  wire logic           to_mem,
  input  wire logic           use_imm,
  input  wire logic [7:0]     imm,
  input  wire logic [2:0]     bit_sel,
  input  wire logic           inc_ptr,
  input  wire logic           last_page,
  input  wire logic [PCW-1:0] call_target,
  input  wire logic [PCW-1:0] cur_pc,
  // Completion
  output logic                busy_q,
  output logic                done_q,
  output logic                skip_q,
  // Program counter side
  output logic                pc_load_q,
  output logic [PCW-1:0]      pc_value_q,
  output logic                stack_push_q,
  output logic [PCW-1:0]      stack_data_q,
  // Table memory
  output logic                table_req_q,
  output logic [PCW-1:0]      table_addr_q,
  input  wire logic [15:0]    table_data,
  // Watchdog
  input  wire logic           timeout_set,
  input  wire logic           powerdown_set,
  output logic                wdt_clear_q,
  output logic                timeout_flag_q,
  output logic                powerdown_flag_q,
  // Register port
  input  wire logic [3:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_write,
  input  wire logic           reg_read,
  output logic [7:0]          reg_rdata_q,
  // Core state
  output logic [7:0]          acc_q
);
  // Table address is page above pointer
  if (PCW != `MXA_PAGEW + 8 || AW > 16) begin : g_chk
    $error("mxa_core widths unsupported");
  end

  mxa_mem_if #(.AW(AW), .DW(8)) mem ();

  mxa_state_e     state_q, state_d;  // Sequencer
  mxa_op_e        op_q;              // Latched operation
  logic [AW-1:0]  addr_q;            // Latched far address
  logic           to_mem_q;          // Result goes to memory
  logic           imm_q_sel;         // Immediate operand
  logic [7:0]     imm_q;             // Immediate value
  logic [2:0]     bit_q;             // Bit position
  logic [PCW-1:0] target_q;          // Call target
  logic [PCW-1:0] pc_q;              // Pc of the instruction
  logic           z_q, c_q, ac_q;    // Arithmetic flags
  logic           ov_q, sc_q, cz_q;  // Signed and chained flags
  logic [7:0]     tptr_q;            // Table pointer
  logic [7:0]     thigh_q;           // Table high byte
  logic [`MXA_PAGEW-1:0] tpage_q;    // Specific table page

  // Operand selection and adder
  wire         accept_w = start && state_q == ST_IDLE;
  wire         exec_w   = state_q == ST_EXEC;
  wire [7:0]   m_w      = mem.rdata;
  wire [7:0]   b_w      = imm_q_sel ? imm_q : m_w;
  wire         sub_w    = op_q == OP_SUB || op_q == OP_SBC;
  // Borrow is the inverted carry, so subtract adds the complement
  wire [7:0]   bx_w     = sub_w ? ~b_w : b_w;
  wire         cin_w    = op_q == OP_SUB ? 1'b1 : (op_q == OP_ADD ? 1'b0 : c_q);
  wire [8:0]   sum_w    = {1'b0, acc_q} + {1'b0, bx_w} + {8'h00, cin_w};
  wire [4:0]   nib_w    = {1'b0, acc_q[3:0]} + {1'b0, bx_w[3:0]} + {4'h0, cin_w};
  wire         ov_w     = (acc_q[7] == bx_w[7]) && (sum_w[7] != acc_q[7]);
  wire [7:0]   mask_w   = 8'h01 << bit_q;
  wire [7:0]   inc_w    = m_w + 8'h01;
  wire [7:0]   dec_w    = m_w - 8'h01;
  // Decimal adjust nibble tests
  wire         lo_adj_w = acc_q[3:0] > `MXA_BCD_MAX || ac_q;
  wire         hi_adj_w = acc_q[7:4] > `MXA_BCD_MAX || c_q;
  wire [7:0]   adj_w    = {hi_adj_w ? `MXA_BCD_ADJ : 4'h0, lo_adj_w ? `MXA_BCD_ADJ : 4'h0};
  wire [8:0]   daa_w    = {1'b0, acc_q} + {1'b0, adj_w};

  logic [7:0] res;     // Result byte
  logic       dest;    // Result routed by to_mem
  logic       wr_acc;  // Accumulator write
  logic       wr_mem;  // Memory write
  logic       upd_z;   // Zero flag only
  logic       upd_ar;  // Five arithmetic flags, and cz on SUB and SBC
  logic       upd_c;   // Carry only
  logic       new_c;   // Carry value for upd_c
  logic       skip;    // Skip condition

  // Per-operation result; same data path as the short forms
  // shared result path
  always_comb begin
    res = m_w; dest = 1'b0; wr_acc = 1'b0; wr_mem = 1'b0;
    upd_z = 1'b0; upd_ar = 1'b0; upd_c = 1'b0; new_c = c_q; skip = 1'b0;
    case (op_q)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        res = sum_w[7:0]; upd_ar = 1'b1; dest = 1'b1;
      end
      OP_AND:  begin res = acc_q & b_w; upd_z = 1'b1; dest = 1'b1; end
      OP_OR:   begin res = acc_q | b_w; upd_z = 1'b1; dest = 1'b1; end
      OP_XOR:  begin res = acc_q ^ b_w; upd_z = 1'b1; dest = 1'b1; end
      OP_CPL:  begin res = ~m_w; upd_z = 1'b1; dest = 1'b1; end
      OP_INC:  begin res = inc_w; upd_z = 1'b1; dest = 1'b1; end
      OP_DEC:  begin res = dec_w; upd_z = 1'b1; dest = 1'b1; end
      OP_RR:   begin res = {m_w[0], m_w[7:1]}; dest = 1'b1; end
      OP_RRC:  begin res = {c_q, m_w[7:1]}; new_c = m_w[0]; upd_c = 1'b1; dest = 1'b1; end
      OP_RL:   begin res = {m_w[6:0], m_w[7]}; dest = 1'b1; end
      OP_RLC:  begin res = {m_w[6:0], c_q}; new_c = m_w[7]; upd_c = 1'b1; dest = 1'b1; end
      OP_MOVR: begin wr_acc = 1'b1; end
      OP_MOVW: begin res = acc_q; wr_mem = 1'b1; end
      OP_BCLR: begin res = m_w & ~mask_w; wr_mem = 1'b1; end
      OP_BSET: begin res = m_w | mask_w; wr_mem = 1'b1; end
      OP_CLR:  begin res = 8'h00; wr_mem = 1'b1; end
      OP_SET:  begin res = 8'hFF; wr_mem = 1'b1; end
      OP_SWAP: begin res = {m_w[3:0], m_w[7:4]}; dest = 1'b1; end
      OP_DAA: begin
        res = daa_w[7:0]; wr_mem = 1'b1; upd_c = 1'b1; new_c = c_q | daa_w[8];
      end
      // Zero test, copying to acc when to_mem is low
      OP_SZ:   begin skip = m_w == 8'h00; wr_acc = !to_mem_q; end
      OP_SNZ:  begin skip = m_w != 8'h00; end
      OP_SZB:  begin skip = !m_w[bit_q]; end
      OP_SNZB: begin skip = m_w[bit_q]; end
      OP_SIZ:  begin res = inc_w; skip = inc_w == 8'h00; dest = 1'b1; end
      OP_SDZ:  begin res = dec_w; skip = dec_w == 8'h00; dest = 1'b1; end
      default: begin end
    endcase
    if (dest) begin
      wr_mem = to_mem_q;
      wr_acc = !to_mem_q;
    end
  end

  wire pcl_w  = wr_mem && addr_q == `MXA_PCL_ADDR;
  wire long_w = skip || pcl_w;
  wire wdt_w  = exec_w && op_q == OP_WDT;
  wire [7:0] ptr_next_w = inc_ptr ? tptr_q + 8'h01 : tptr_q;

  // read from the full far address
  assign mem.re    = accept_w;
  assign mem.addr  = state_q == ST_IDLE ? far_addr : addr_q;
  assign mem.we    = (exec_w && wr_mem) || state_q == ST_TABLE;
  assign mem.wdata = state_q == ST_TABLE ? table_data[7:0] : res;

  mxa_dmem #(.AW(AW), .DW(8), .DEPTH(`MXA_DEPTH)) u_dmem (
    .clock (clock),
    .reset (reset),
    .mem   (mem.slave)
  );

  // Next state: table and long forms add a third cycle
  // cycle counts
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (accept_w) state_d = ST_EXEC;
      ST_EXEC:  state_d = op_q == OP_TAB ? ST_TABLE : (long_w ? ST_TAIL : ST_IDLE);
      ST_TABLE: state_d = ST_IDLE;
      ST_TAIL:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // Sequencer and completion
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE; busy_q <= 1'b0; done_q <= 1'b0; skip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= state_d != ST_IDLE;
      done_q  <= state_q != ST_IDLE && state_d == ST_IDLE;
      skip_q  <= exec_w ? skip : (done_q ? 1'b0 : skip_q && !done_q);
    end
  end

  // Request latch
  always_ff @(posedge clock) begin
    if (reset) begin
      op_q <= OP_NOP; addr_q <= '0; to_mem_q <= 1'b0; imm_q_sel <= 1'b0;
      imm_q <= 8'h00; bit_q <= 3'h0; target_q <= '0; pc_q <= '0;
    end else if (accept_w) begin
      op_q <= op; addr_q <= far_addr; to_mem_q <= to_mem; imm_q_sel <= use_imm;
      imm_q <= imm; bit_q <= bit_sel; target_q <= call_target; pc_q <= cur_pc;
    end
  end

  // Flags and accumulator; the register port loses to execution
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_q <= 8'h00; z_q <= 1'b0; c_q <= 1'b0; ac_q <= 1'b0;
      ov_q <= 1'b0; sc_q <= 1'b0; cz_q <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `MXA_R_ACC) acc_q <= reg_wdata;
      if (reg_write && reg_addr == `MXA_R_STATUS) begin
        {cz_q, sc_q, ov_q, ac_q, c_q, z_q} <= reg_wdata[`MXA_B_CZ:`MXA_B_Z];
      end
      if (exec_w && wr_acc) acc_q <= res;
      if (exec_w && (upd_z || upd_ar)) z_q <= res == 8'h00;
      if (exec_w && upd_c) c_q <= new_c;
      if (exec_w && upd_ar) begin
        c_q <= sum_w[8]; ac_q <= nib_w[4]; ov_q <= ov_w; sc_q <= ov_w ^ sum_w[7];
        if (op_q == OP_SUB) cz_q <= res == 8'h00;
        if (op_q == OP_SBC) cz_q <= res == 8'h00 && cz_q;
      end
    end
  end

  // Program counter, stack and table requests
  always_ff @(posedge clock) begin
    if (reset) begin
      pc_load_q <= 1'b0; pc_value_q <= '0; stack_push_q <= 1'b0; stack_data_q <= '0;
      table_req_q <= 1'b0; table_addr_q <= '0; tptr_q <= 8'h00; tpage_q <= '0; thigh_q <= 8'h00;
    end else begin
      pc_load_q    <= 1'b0;
      stack_push_q <= 1'b0;
      table_req_q  <= 1'b0;
      if (reg_write && reg_addr == `MXA_R_TPTR)  tptr_q  <= reg_wdata;
      if (reg_write && reg_addr == `MXA_R_TPAGE) tpage_q <= reg_wdata[`MXA_PAGEW-1:0];
      if (exec_w && pcl_w) begin
        pc_load_q  <= 1'b1;
        pc_value_q <= {pc_q[PCW-1:8], res};
      end
      if (exec_w && op_q == OP_CALL) begin
        stack_push_q <= 1'b1;
        stack_data_q <= pc_q + 1'b1;
        pc_load_q    <= 1'b1;
        pc_value_q   <= target_q;
      end
      if (accept_w && op == OP_TAB) begin
        tptr_q       <= ptr_next_w;
        table_req_q  <= 1'b1;
        table_addr_q <= {last_page ? `MXA_LAST_PAGE : tpage_q, ptr_next_w};
      end
      if (state_q == ST_TABLE) thigh_q <= table_data[15:8];
    end
  end

  // Watchdog flags: a set in the clearing cycle wins
  // watchdog clear
  always_ff @(posedge clock) begin
    if (reset) begin
      wdt_clear_q <= 1'b0; timeout_flag_q <= 1'b0; powerdown_flag_q <= 1'b0;
    end else begin
      wdt_clear_q      <= wdt_w;
      timeout_flag_q   <= timeout_set || (timeout_flag_q && !wdt_w);
      powerdown_flag_q <= powerdown_set || (powerdown_flag_q && !wdt_w);
    end
  end

  // Register read mux; unmapped offsets read zero
  wire [7:0] status_w = {powerdown_flag_q, timeout_flag_q, cz_q, sc_q, ov_q, ac_q, c_q, z_q};
  wire [7:0] rmux_w   = reg_addr == `MXA_R_ACC    ? acc_q :
                        reg_addr == `MXA_R_STATUS ? status_w :
                        reg_addr == `MXA_R_TPTR   ? tptr_q :
                        reg_addr == `MXA_R_THIGH  ? thigh_q :
                        reg_addr == `MXA_R_TPAGE  ? {3'h0, tpage_q} : 8'h00;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) reg_rdata_q <= 8'h00;
    else       reg_rdata_q <= reg_read ? rmux_w : 8'h00;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_exec_short;
    exec_w && !long_w && op_q != OP_TAB;
  endsequence
  sequence s_exec_skip;
    exec_w && skip;
  endsequence

  two_cycle_a: assert property (s_exec_short |=> done_q && !busy_q)
    else $error("short instruction did not end after two cycles");
  skip_len_a: assert property (s_exec_skip |=> !done_q ##1 done_q && skip_q)
    else $error("skip did not take three cycles");
  pcl_len_a: assert property (exec_w && pcl_w |=> pc_load_q && !done_q ##1 done_q)
    else $error("pc low write did not take three cycles");
  table_len_a: assert property (accept_w && op == OP_TAB |=> table_req_q ##1 !done_q ##1 done_q)
    else $error("table read did not take three cycles");
  table_ptr_a: assert property (accept_w && op == OP_TAB && inc_ptr |=> tptr_q == $past(tptr_q) + 8'h01)
    else $error("table pointer not advanced");
  adc_sum_a: assert property (exec_w && op_q == OP_ADC && !to_mem_q
    |=> acc_q == $past(acc_q) + $past(b_w) + {7'h00, $past(c_q)})
    else $error("add with carry wrong");
  and_flag_a: assert property (exec_w && op_q == OP_AND |=> c_q == $past(c_q) && ov_q == $past(ov_q))
    else $error("logic operation changed arithmetic flags");
  call_push_a: assert property (exec_w && op_q == OP_CALL
    |=> stack_push_q && stack_data_q == $past(pc_q) + 1'b1 && pc_value_q == $past(target_q))
    else $error("call push or target wrong");
  wdt_clr_a: assert property (wdt_w && !timeout_set && !powerdown_set
    |=> wdt_clear_q && !timeout_flag_q && !powerdown_flag_q)
    else $error("watchdog clear left flags set");
  daa_flag_a: assert property (exec_w && op_q == OP_DAA |=> z_q == $past(z_q) && ac_q == $past(ac_q))
    else $error("decimal adjust changed other flags");
endmodule // mxa_core

// [mxa_defs.svh]
`ifndef MXA_DEFS_SVH
`define MXA_DEFS_SVH

// Data memory: eight sectors of 256 bytes
`define MXA_AW        11
`define MXA_DW        8
`define MXA_DEPTH     2048
// Program counter and table page widths
`define MXA_PCW       13
`define MXA_PAGEW     5
`define MXA_LAST_PAGE 5'h1F
// Program counter low byte in sector 0
`define MXA_PCL_ADDR  11'h006
// Instruction lengths in clock cycles
`define MXA_CYC_BASE  2
`define MXA_CYC_LONG  3
// Decimal adjust limits
`define MXA_BCD_MAX   4'h9
`define MXA_BCD_ADJ   4'h6
// Register port offsets
`define MXA_R_ACC     4'h0
`define MXA_R_STATUS  4'h1
`define MXA_R_TPTR    4'h2
`define MXA_R_THIGH   4'h3
`define MXA_R_TPAGE   4'h4
// Status field positions
`define MXA_B_Z       0
`define MXA_B_C       1
`define MXA_B_AC      2
`define MXA_B_OV      3
`define MXA_B_SC      4
`define MXA_B_CZ      5
`define MXA_B_TO      6
`define MXA_B_PDF     7

`endif

// [mxa_pkg.sv]
package mxa_pkg;
  // Operations of the extended group plus call and watchdog clear
  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_ADD  = 5'h01, OP_ADC  = 5'h02, OP_SUB  = 5'h03,
    OP_SBC  = 5'h04, OP_AND  = 5'h05, OP_OR   = 5'h06, OP_XOR  = 5'h07,
    OP_CPL  = 5'h08, OP_INC  = 5'h09, OP_DEC  = 5'h0A, OP_RR   = 5'h0B,
    OP_RRC  = 5'h0C, OP_RL   = 5'h0D, OP_RLC  = 5'h0E, OP_MOVR = 5'h0F,
    OP_MOVW = 5'h10, OP_BCLR = 5'h11, OP_BSET = 5'h12, OP_CLR  = 5'h13,
    OP_SET  = 5'h14, OP_SWAP = 5'h15, OP_DAA  = 5'h16, OP_SZ   = 5'h17,
    OP_SNZ  = 5'h18, OP_SZB  = 5'h19, OP_SNZB = 5'h1A, OP_SIZ  = 5'h1B,
    OP_SDZ  = 5'h1C, OP_TAB  = 5'h1D, OP_CALL = 5'h1E, OP_WDT  = 5'h1F
  } mxa_op_e;
  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_TABLE = 2'b10,
    ST_TAIL  = 2'b11
  } mxa_state_e;
endpackage

// [mxa_mem_if.sv]
`timescale 1ns/1ns
interface mxa_mem_if #(parameter int AW = 11, parameter int DW = 8);
  logic [AW-1:0] addr;   // Byte address
  logic [DW-1:0] wdata;  // Write data
  logic [DW-1:0] rdata;  // Registered read data
  logic          we;     // Write enable
  logic          re;     // Read enable
  modport master (output addr, output wdata, output we, output re, input rdata);
  modport slave  (input addr, input wdata, input we, input re, output rdata);
endinterface // mxa_mem_if

// [mxa_dmem.sv]
`timescale 1ns/1ns
`include "mxa_defs.svh"
module mxa_dmem #(
  parameter int AW    = `MXA_AW,
  parameter int DW    = `MXA_DW,
  parameter int DEPTH = `MXA_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Memory access
  mxa_mem_if.slave mem
);
  logic [DW-1:0] ram [DEPTH];  // Storage, no reset
  logic [DW-1:0] rdata_q;      // Read register

  // Depth must fit the address
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("mxa_dmem depth exceeds address range");
  end

  // Write port
  always_ff @(posedge clock) begin
    if (mem.we) begin
      ram[mem.addr] <= mem.wdata;
    end
  end

  // Read data come from a register one cycle later
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (mem.re) begin
      rdata_q <= ram[mem.addr];
    end
  end

  assign mem.rdata = rdata_q;
endmodule // mxa_dmem

// [mxa_core_tb_top.sv]
`timescale 1ns/1ns
module mxa_core_tb_top;
  import mxa_pkg::*;
  // Core inputs, all driven from the bench
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  mxa_op_e     op = OP_NOP;
  logic [10:0] far_addr = 11'h000;
  logic        to_mem = 1'b0;
  logic        use_imm = 1'b0;
  logic [7:0]  imm = 8'h00;
  logic [2:0]  bit_sel = 3'h0;
  logic        inc_ptr = 1'b0;
  logic        last_page = 1'b0;
  logic [12:0] call_target = 13'h0000;
  logic [12:0] cur_pc = 13'h0000;
  logic [15:0] table_data = 16'hFFFF;
  logic        timeout_set = 1'b0;
  logic        powerdown_set = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  // Core outputs
  logic        busy_q, done_q, skip_q, pc_load_q, stack_push_q;
  logic        table_req_q, wdt_clear_q, timeout_flag_q, powerdown_flag_q;
  logic [12:0] pc_value_q, stack_data_q, table_addr_q;
  logic [7:0]  reg_rdata_q, acc_q;
  // Counters and per-instruction settings
  int          failures = 0;
  int          checks = 0;
  logic        n_ui = 1'b0;
  logic [7:0]  n_im = 8'h00;
  logic        n_inc = 1'b0;
  logic        n_last = 1'b0;
  logic [12:0] n_pc = 13'h0000;
  logic [12:0] n_tgt = 13'h0000;
  logic [15:0] n_tab = 16'h0000;
  // Results captured while an instruction runs
  logic        g_skip, g_load, g_push, g_wdt, g_req;
  logic [12:0] g_pcv, g_stk, g_taddr;
  // Decimal adjust cases: acc, status, memory result, status result
  logic [31:0] daa_t [6] = '{32'h45194519, 32'h4B005100, 32'h43044904,
                             32'hB2001202, 32'h23028302, 32'hAB001102};
  // Flag-neutral cases: op, operand, result
  logic [23:0] neu_t [7] = '{24'h0B0180, 24'h0D8103, 24'h153CC3, 24'h1400FF,
                             24'h120008, 24'h13FF00, 24'h11FFF7};
  // Skip cases: op, operand, cycles, memory result
  logic [31:0] skp_t [12] = '{32'h17000300, 32'h17010201, 32'h18010301, 32'h18000200,
                              32'h19F703F7, 32'h19080208, 32'h1A080308, 32'h1AF702F7,
                              32'h1BFF0300, 32'h1B000201, 32'h1C010300, 32'h1C050204};

  mxa_core i_dut (
    .clock, .reset, .start, .op, .far_addr, .to_mem, .use_imm, .imm, .bit_sel, .inc_ptr,
    .last_page, .call_target, .cur_pc, .busy_q, .done_q, .skip_q, .pc_load_q, .pc_value_q,
    .stack_push_q, .stack_data_q, .table_req_q, .table_addr_q, .table_data, .timeout_set,
    .powerdown_set, .wdt_clear_q, .timeout_flag_q, .powerdown_flag_q, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata_q, .acc_q
  );

  // 100 MHz clock
  always #5 clock = ~clock;

  // Compare and count; four-state so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("Summary: %0d mismatches in %0d comparisons", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Register read; data stands only in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    check(16'(reg_rdata_q & m), 16'(e));
  endtask

  // Issue one instruction and count cycles up to done_q, bounded
  task automatic exec(input mxa_op_e o, input logic [10:0] a, input logic tm, input int cyc);
    int n;
    n = 0;
    g_wdt = 1'b0;
    g_req = 1'b0;
    // Pulses may fall before done_q on long forms, so gather them
    g_load = 1'b0;
    g_push = 1'b0;
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    far_addr <= a;
    to_mem <= tm;
    use_imm <= n_ui;
    imm <= n_im;
    bit_sel <= 3'h3;
    inc_ptr <= n_inc;
    last_page <= n_last;
    cur_pc <= n_pc;
    call_target <= n_tgt;
    // Table bus carries junk until its valid cycle, then holds the valid word
    table_data <= ~n_tab;
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(negedge clock);
      n++;
      g_wdt |= wdt_clear_q;
      g_load |= pc_load_q;
      g_push |= stack_push_q;
      if (n == 1) check(16'(busy_q), 16'h0001);
      if (table_req_q === 1'b1) begin
        g_req = 1'b1;
        g_taddr = table_addr_q;
        @(posedge clock);
        table_data <= n_tab;
      end
    end while (done_q !== 1'b1 && n < 6);
    check(16'(n), 16'(cyc));
    g_skip = skip_q;
    g_pcv = pc_value_q;
    g_stk = stack_data_q;
  endtask

  // Memory byte, then accumulator and status
  task automatic prep(input logic [10:0] a, input logic [7:0] m, input logic [7:0] ac,
                      input logic [7:0] st);
    wr(4'h0, m);
    exec(OP_MOVW, a, 1'b1, 2);
    wr(4'h0, ac);
    wr(4'h1, st);
  endtask

  // Memory byte seen through the accumulator
  task automatic mem_get(input logic [10:0] a, input logic [7:0] v);
    exec(OP_MOVR, a, 1'b0, 2);
    rd(4'h0, v);
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check(16'({acc_q, busy_q}), 16'h0000);
    rd(4'h7, 8'h00);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h3F);
    prep(11'h7A5, 8'h3C, 8'h00, 8'h00);
    prep(11'h0A5, 8'hC3, 8'h00, 8'h00);
    mem_get(11'h7A5, 8'h3C);
    mem_get(11'h0A5, 8'hC3);
    prep(11'h123, 8'h01, 8'h7F, 8'h00);
    exec(OP_ADD, 11'h123, 1'b0, 2);
    rd(4'h0, 8'h80);
    rd(4'h1, 8'h0C);
    wr(4'h0, 8'hFF);
    n_ui = 1'b1;
    n_im = 8'h01;
    exec(OP_ADD, 11'h123, 1'b0, 2);
    rd(4'h1, 8'h07);
    wr(4'h0, 8'hF0);
    wr(4'h1, 8'h1E);
    n_im = 8'h3C;
    exec(OP_AND, 11'h123, 1'b0, 2);
    rd(4'h0, 8'h30);
    rd(4'h1, 8'h1E);
    n_ui = 1'b0;
    prep(11'h456, 8'h70, 8'h0F, 8'h02);
    exec(OP_ADC, 11'h456, 1'b1, 2);
    rd(4'h1, 8'h0C);
    mem_get(11'h456, 8'h80);
    // Carry-in sum to the accumulator, signed wrap
    wr(4'h1, 8'h02);
    exec(OP_ADC, 11'h456, 1'b0, 2);
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h1A);
    prep(11'h222, 8'h0F, 8'hF0, 8'h00);
    exec(OP_OR, 11'h222, 1'b0, 2);
    rd(4'h0, 8'hFF);
    exec(OP_XOR, 11'h222, 1'b0, 2);
    rd(4'h0, 8'hF0);
    exec(OP_INC, 11'h222, 1'b1, 2);
    mem_get(11'h222, 8'h10);
    prep(11'h5F0, 8'h0F, 8'hF0, 8'h1E);
    exec(OP_AND, 11'h5F0, 1'b1, 2);
    rd(4'h1, 8'h1F);
    mem_get(11'h5F0, 8'h00);
    prep(11'h2AA, 8'h5A, 8'h00, 8'h1F);
    exec(OP_CPL, 11'h2AA, 1'b0, 2);
    rd(4'h1, 8'h1E);
    rd(4'h0, 8'hA5);
    mem_get(11'h2AA, 8'h5A);
    prep(11'h2AA, 8'hFF, 8'h00, 8'h1E);
    exec(OP_CPL, 11'h2AA, 1'b1, 2);
    rd(4'h1, 8'h1F);
    mem_get(11'h2AA, 8'h00);
    prep(11'h301, 8'h01, 8'h77, 8'h1E);
    exec(OP_DEC, 11'h301, 1'b1, 2);
    rd(4'h1, 8'h1F);
    exec(OP_DEC, 11'h301, 1'b0, 2);
    rd(4'h0, 8'hFF);
    mem_get(11'h301, 8'h00);
    for (int i = 0; i < 6; i++) begin
      prep(11'h600, 8'h00, daa_t[i][31:24], daa_t[i][23:16]);
      exec(OP_DAA, 11'h600, 1'b1, 2);
      rd(4'h1, daa_t[i][7:0]);
      mem_get(11'h600, daa_t[i][15:8]);
    end
    for (int i = 0; i < 7; i++) begin
      prep(11'h10F, neu_t[i][15:8], 8'h00, 8'h1E);
      exec(mxa_op_e'(neu_t[i][20:16]), 11'h10F, 1'b1, 2);
      rd(4'h1, 8'h1E);
      mem_get(11'h10F, neu_t[i][7:0]);
    end
    prep(11'h10F, 8'h01, 8'h00, 8'h00);
    exec(OP_RRC, 11'h10F, 1'b1, 2);
    rd(4'h1, 8'h02);
    mem_get(11'h10F, 8'h00);
    prep(11'h10F, 8'h80, 8'h55, 8'h00);
    exec(OP_RLC, 11'h10F, 1'b0, 2);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h02);
    prep(11'h700, 8'h05, 8'h05, 8'h00);
    exec(OP_SUB, 11'h700, 1'b0, 2);
    rd(4'h1, 8'h23, 8'h3B);
    wr(4'h0, 8'h00);
    exec(OP_SUB, 11'h700, 1'b1, 2);
    rd(4'h1, 8'h10, 8'h3B);
    mem_get(11'h700, 8'hFB);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h02);
    n_ui = 1'b1;
    n_im = 8'h00;
    exec(OP_SBC, 11'h700, 1'b0, 2);
    rd(4'h1, 8'h03, 8'h3B);
    n_ui = 1'b0;
    for (int i = 0; i < 12; i++) begin
      prep(11'h3F0, skp_t[i][23:16], 8'h00, 8'h2B);
      exec(mxa_op_e'(skp_t[i][28:24]), 11'h3F0, 1'b1, int'(skp_t[i][15:8]));
      check(16'(g_skip), 16'(skp_t[i][15:8] == 8'h03));
      rd(4'h1, 8'h2B);
      mem_get(11'h3F0, skp_t[i][7:0]);
    end
    // Zero test copying the operand to the accumulator
    wr(4'h0, 8'h00);
    exec(OP_SZ, 11'h3F0, 1'b0, 2);
    rd(4'h0, 8'h04);
    wr(4'h0, 8'h42);
    n_pc = 13'h1234;
    exec(OP_MOVW, 11'h006, 1'b1, 3);
    check(16'({g_load, g_pcv}), 16'h3242);
    exec(OP_ADD, 11'h006, 1'b1, 3);
    check(16'({g_load, g_pcv}), 16'h3284);
    wr(4'h2, 8'hFF);
    wr(4'h4, 8'h0A);
    n_inc = 1'b1;
    n_tab = 16'h9C5A;
    exec(OP_TAB, 11'h345, 1'b1, 3);
    check(16'({g_req, g_taddr}), 16'h2A00);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h9C);
    mem_get(11'h345, 8'h5A);
    n_inc = 1'b0;
    n_last = 1'b1;
    n_tab = 16'h36E1;
    wr(4'h2, 8'h7E);
    exec(OP_TAB, 11'h345, 1'b1, 3);
    check(16'({g_req, g_taddr}), 16'h3F7E);
    rd(4'h3, 8'h36);
    mem_get(11'h345, 8'hE1);
    n_pc = 13'h0ABC;
    n_tgt = 13'h1555;
    exec(OP_CALL, 11'h000, 1'b0, 2);
    check(16'({g_push, g_stk}), 16'h2ABD);
    check(16'({g_load, g_pcv}), 16'h3555);
    @(posedge clock);
    timeout_set <= 1'b1;
    powerdown_set <= 1'b1;
    @(posedge clock);
    timeout_set <= 1'b0;
    powerdown_set <= 1'b0;
    rd(4'h1, 8'hC0, 8'hC0);
    exec(OP_WDT, 11'h000, 1'b0, 2);
    check(16'({g_wdt, timeout_flag_q, powerdown_flag_q}), 16'h0004);
    rd(4'h1, 8'h00, 8'hC0);
    final_report();
  end
endmodule // mxa_core_tb_top
